// [design/spw_regs.sv]
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spw_regs
    import spw_pkg::*;
#(
    parameter int unsigned PER0_CYCLES = PER0_CYC,
    parameter int unsigned PER1_CYCLES = PER1_CYC,
    parameter int unsigned PER2_CYCLES = PER2_CYC,
    parameter int unsigned PER3_CYCLES = PER3_CYC
) (
    // clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // chip state and events
    input wire logic normal_mode,
    input wire logic chip_select_n,
    input wire logic pulse_pin_enable,
    input wire spw_event_type events,
    // outputs to the chip
    output logic pulse_out,
    output logic irq_out_n,
    output logic frame_based_wake_en,
    output spw_cfg_type cfg
);

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic rd_wait_q;
    logic [5:0] idx_q;
    logic [31:0] hrdata_q;
    logic addr_ok;
    logic wr_en;
    logic [7:0] wdat;
    logic [7:0] rd_mux;

    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_q;
    assign wdat = hwdata[7:0];
    assign hreadyout = !rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
            idx_q <= 6'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            rd_wait_q <= addr_ok && !hwrite;
            if (addr_ok) begin
                idx_q <= haddr[7:2];
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] duty_q;
    logic [7:0] rate_q;
    logic [7:0] therm_q;
    logic [7:0] scr_lo_q;
    logic [7:0] scr_hi_q;
    logic [7:0] swk_q;
    logic lock_bit_q;
    logic locked_q;
    logic cs_rise;

    // duty and rate: soft reset clears, restart keeps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_q <= RST_ZERO;
            rate_q <= RST_ZERO;
        end else if (events.soft_reset) begin
            duty_q <= RST_ZERO;
            rate_q <= RST_ZERO;
        end else if (wr_en) begin
            if (idx_q == IDX_DUTY) begin
                duty_q <= wdat;
            end
            if (idx_q == IDX_RATE) begin
                rate_q <= wdat & WMASK_RATE;
            end
        end
    end

    // thermal trip and current limit, lockable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            therm_q <= RST_THERM;
        end else if (events.soft_reset) begin
            if (!lock_bit_q) begin
                therm_q <= RST_THERM;
            end
        end else if (wr_en && idx_q == IDX_THERM && !locked_q) begin
            therm_q <= wdat & WMASK_THERM;
        end
    end

    // lock bit and lock state, cleared only by power-on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_bit_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            if (wr_en && idx_q == IDX_LOCK && !locked_q) begin
                lock_bit_q <= wdat[LOCK_BIT];
            end
            if (lock_bit_q && cs_rise) begin
                locked_q <= 1'b1;
            end
        end
    end

    // scratch bytes: host storage only, cleared by power-on only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scr_lo_q <= RST_ZERO;
            scr_hi_q <= RST_ZERO;
        end else if (wr_en && normal_mode) begin
            if (idx_q == IDX_SCR_LO) begin
                scr_lo_q <= wdat;
            end
            if (idx_q == IDX_SCR_HI) begin
                scr_hi_q <= wdat;
            end
        end
    end

    // selective-wake control; hardware clear of valid wins over host set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            swk_q <= RST_ZERO;
        end else if (events.soft_reset) begin
            swk_q <= RST_ZERO;
        end else if (events.restart) begin
            swk_q <= swk_q & RST_KEEP_SWK;
        end else begin
            if (wr_en && idx_q == IDX_SWK) begin
                swk_q <= wdat & WMASK_SWK;
            end
            if (events.wake_up || events.swk_cfg_changed) begin
                swk_q[VALID_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read data, taken one cycle into the data phase
    // ------------------------------------------------------------
    always_comb begin
        unique case (idx_q)
            IDX_LOCK: rd_mux = {7'h00, lock_bit_q};
            IDX_DUTY: rd_mux = duty_q;
            IDX_RATE: rd_mux = rate_q;
            IDX_THERM: rd_mux = therm_q;
            IDX_SCR_LO: rd_mux = scr_lo_q;
            IDX_SCR_HI: rd_mux = scr_hi_q;
            IDX_SWK: rd_mux = swk_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_wait_q) begin
            hrdata_q <= {24'h000000, rd_mux};
        end
    end

    // ------------------------------------------------------------
    // chip select synchroniser and rising edge
    // ------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic cs_filt_q;
    logic cs_filt_d;

    assign cs_filt_d = (cs_s2_q == cs_s3_q) ? cs_s3_q : cs_filt_q;
    assign cs_rise = cs_filt_d && !cs_filt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            cs_filt_q <= 1'b1;
        end else begin
            cs_s1_q <= chip_select_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            cs_filt_q <= cs_filt_d;
        end
    end

    // ------------------------------------------------------------
    // pulse generator
    // ------------------------------------------------------------
    spw_pwm_state_type state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0] duty_act_q;
    logic [1:0] rate_act_q;
    logic [CNT_W-1:0] per_len;
    logic period_end;
    logic pulse_q;
    logic pulse_d;
    logic [31:0] cmp_lhs;
    logic [31:0] cmp_rhs;

    always_comb begin
        unique case (rate_act_q)
            2'b00: per_len = CNT_W'(PER0_CYCLES);
            2'b01: per_len = CNT_W'(PER1_CYCLES);
            2'b10: per_len = CNT_W'(PER2_CYCLES);
            2'b11: per_len = CNT_W'(PER3_CYCLES);
        endcase
    end

    assign period_end = (cnt_q == per_len - CNT_W'(1));
    assign cmp_lhs = 32'(cnt_q) * DUTY_STEPS;
    assign cmp_rhs = 32'(duty_act_q) * 32'(per_len);

    always_comb begin
        if (duty_act_q == DUTY_OFF) begin
            pulse_d = 1'b0;
        end else if (duty_act_q == DUTY_FULL) begin
            pulse_d = 1'b1;
        end else begin
            pulse_d = cmp_lhs < cmp_rhs;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= PWM_IDLE;
        end else begin
            unique case (state_q)
                PWM_IDLE: if (pulse_pin_enable) state_q <= PWM_RUN;
                PWM_RUN: if (!pulse_pin_enable) state_q <= PWM_IDLE;
                default: state_q <= PWM_IDLE;
            endcase
        end
    end

    // settings are taken over only when idle or at a period boundary
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            duty_act_q <= RST_ZERO;
            rate_act_q <= 2'b00;
        end else if (state_q != PWM_RUN || period_end) begin
            cnt_q <= '0;
            duty_act_q <= duty_q;
            rate_act_q <= rate_q[RATE_MSB:RATE_LSB];
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= (state_q == PWM_RUN) && pulse_d;
        end
    end

    assign pulse_out = pulse_q;

    // ------------------------------------------------------------
    // interrupt pin and configuration outputs
    // ------------------------------------------------------------
    logic irq_n_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= !(events.bus_timeout && swk_q[TO_EN_BIT]);
        end
    end

    assign irq_out_n = irq_n_q;
    assign frame_based_wake_en = swk_q[VALID_BIT];
    assign cfg.overheat_trip_sel = therm_q[TRIP_BIT];
    assign cfg.supply_current_limit_sel = therm_q[LIM_MSB:LIM_LSB];
    assign cfg.osc_trim_mode = swk_q[OSC_BIT];
    assign cfg.trim_unlocked = swk_q[KEY_MSB:KEY_LSB] == KEY_OPEN;
    assign cfg.bus_timeout_irq_enable = swk_q[TO_EN_BIT];
    assign cfg.wake_config_valid = swk_q[VALID_BIT];
    assign cfg.cfg_locked = locked_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_duty_boundary:
    assert property ($changed(duty_act_q) |-> $past(state_q) != PWM_RUN || $past(period_end))
    else $error("active duty changed inside a period");

    a_duty_static:
    assert property (state_q == PWM_RUN && duty_act_q == DUTY_OFF |=> !pulse_out)
    else $error("zero duty produced an on level");

    a_duty_full:
    assert property (state_q == PWM_RUN && duty_act_q == DUTY_FULL
        && $past(duty_act_q) == DUTY_FULL |=> pulse_out)
    else $error("full duty produced an off level");

    a_rate_period:
    assert property (rate_act_q == 2'b10 |-> per_len == CNT_W'(PER2_CYCLES))
    else $error("period length does not follow rate");

    a_rate_boundary:
    assert property ($changed(rate_act_q) |-> $past(state_q) != PWM_RUN || $past(period_end))
    else $error("rate changed inside a period");

    a_rsvd_read:
    assert property (rd_wait_q && idx_q == IDX_SWK |=> hrdata[3:1] == 3'h0
        && hrdata[31:8] == 24'h0)
    else $error("reserved bits read nonzero");

    a_lock_soft:
    assert property (lock_bit_q && events.soft_reset |=> $stable(therm_q))
    else $error("soft reset changed locked settings");

    a_scratch_soft:
    assert property (events.soft_reset && !wr_en |=> $stable(scr_lo_q) && $stable(scr_hi_q))
    else $error("soft reset altered scratch");

    a_scratch_mode:
    assert property (!normal_mode |=> $stable(scr_lo_q) && $stable(scr_hi_q))
    else $error("scratch written outside normal mode");

    a_scratch_host:
    assert property ($changed(scr_lo_q) || $changed(scr_hi_q) |-> $past(wr_en) && $past(normal_mode))
    else $error("scratch changed without a host write");

    a_timeout_gate:
    assert property (events.bus_timeout && !swk_q[TO_EN_BIT] |=> irq_out_n)
    else $error("masked time-out drove the interrupt");

    a_timeout_fire:
    assert property (events.bus_timeout && swk_q[TO_EN_BIT] |=> !irq_out_n)
    else $error("enabled time-out missing on interrupt");

    a_valid_clear:
    assert property (events.wake_up && !events.soft_reset |=> !frame_based_wake_en)
    else $error("wake did not clear valid flag");

    a_lock_take:
    assert property (lock_bit_q && cs_rise |=> locked_q ##1 locked_q)
    else $error("lock not taken on chip select rise");

endmodule

// [design/spw_pkg.sv]
package spw_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LOCK = 6'h0F;
    localparam logic [5:0] IDX_DUTY = 6'h18;
    localparam logic [5:0] IDX_RATE = 6'h1C;
    localparam logic [5:0] IDX_THERM = 6'h1D;
    localparam logic [5:0] IDX_SCR_LO = 6'h1E;
    localparam logic [5:0] IDX_SCR_HI = 6'h1F;
    localparam logic [5:0] IDX_SWK = 6'h20;

    // ------------------------------------------------------------
    // reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_THERM = 8'h01;
    localparam logic [7:0] WMASK_RATE = 8'h03;
    localparam logic [7:0] WMASK_THERM = 8'h07;
    localparam logic [7:0] WMASK_SWK = 8'hF1;
    localparam logic [7:0] WMASK_LOCK = 8'h01;
    localparam logic [7:0] RST_KEEP_SWK = 8'hF0;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hFF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TRIP_BIT = 2;
    localparam int LIM_MSB = 1;
    localparam int LIM_LSB = 0;
    localparam int RATE_MSB = 1;
    localparam int RATE_LSB = 0;
    localparam int OSC_BIT = 7;
    localparam int KEY_MSB = 6;
    localparam int KEY_LSB = 5;
    localparam int TO_EN_BIT = 4;
    localparam int VALID_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam logic [1:0] KEY_OPEN = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned RATE0_HZ = 100;
    localparam int unsigned RATE1_HZ = 200;
    localparam int unsigned RATE2_HZ = 325;
    localparam int unsigned RATE3_HZ = 400;
    localparam int unsigned PER0_CYC = CLK_HZ / RATE0_HZ;
    localparam int unsigned PER1_CYC = CLK_HZ / RATE1_HZ;
    localparam int unsigned PER2_CYC = CLK_HZ / RATE2_HZ;
    localparam int unsigned PER3_CYC = CLK_HZ / RATE3_HZ;
    localparam int CNT_W = 17;
    localparam int unsigned DUTY_STEPS = 255;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWM_IDLE = 2'b00,
        PWM_RUN = 2'b01
    } spw_pwm_state_type;

    typedef struct packed {
        logic soft_reset;
        logic restart;
        logic wake_up;
        logic swk_cfg_changed;
        logic bus_timeout;
    } spw_event_type;

    typedef struct packed {
        logic overheat_trip_sel;
        logic [1:0] supply_current_limit_sel;
        logic osc_trim_mode;
        logic trim_unlocked;
        logic bus_timeout_irq_enable;
        logic wake_config_valid;
        logic cfg_locked;
    } spw_cfg_type;

endpackage

// [test/spw_host.sv]
`timescale 1ns/1ps
module spw_host (
    // clock
    input wire logic hclk,
    // ahb-lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end

    // address phase held until the slave is ready
    task automatic addr_phase(input logic [5:0] idx, input logic wr);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, idx, 2'b00};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask

    task automatic write(input logic [5:0] idx, input logic [7:0] v);
        addr_phase(idx, 1'b1);
        hwdata <= {24'h000000, v};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // released data lines show a changed pattern
        hwdata <= ~{24'h000000, v};
    endtask

    task automatic read(input logic [5:0] idx, output logic [31:0] v);
        addr_phase(idx, 1'b0);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        v = hrdata;
    endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import spw_pkg::*;
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] rst;
        logic [7:0] wd;
        logic [7:0] exp;
    } spw_row_type;
    localparam int LIMIT = 20000;
    localparam int unsigned PER [4] = '{200, 100, 60, 50};
    localparam spw_row_type ROWS [6] = '{
        '{IDX_RATE, 8'h00, 8'hFF, 8'h03},
        '{IDX_THERM, 8'h01, 8'hFE, 8'h06},
        '{IDX_SCR_LO, 8'h00, 8'hA5, 8'hA5},
        '{IDX_SCR_HI, 8'h00, 8'h5A, 8'h5A},
        '{IDX_SWK, 8'h00, 8'hFF, 8'hF1},
        '{6'h05, 8'h00, 8'hFF, 8'h00}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic normal_mode = 1'b1;
    logic chip_select_n = 1'b1;
    logic pulse_pin_enable = 1'b0;
    spw_event_type ev = '0;
    logic pulse_out;
    logic irq_out_n;
    logic frame_based_wake_en;
    spw_cfg_type cfg;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    int h;
    logic [31:0] d;

    always #50 hclk = ~hclk;

    spw_regs #(.PER0_CYCLES(PER[0]), .PER1_CYCLES(PER[1]), .PER2_CYCLES(PER[2]),
        .PER3_CYCLES(PER[3])) spw_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .normal_mode(normal_mode),
        .chip_select_n(chip_select_n), .pulse_pin_enable(pulse_pin_enable), .events(ev),
        .pulse_out(pulse_out), .irq_out_n(irq_out_n),
        .frame_based_wake_en(frame_based_wake_en), .cfg(cfg));

    spw_host spw_host_i (
        .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] v);
        @(posedge hclk);
        spw_host_i.write(idx, v);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] v);
        @(posedge hclk);
        spw_host_i.read(idx, d);
        check({hresp, d}, {1'b0, 24'h000000, v});
    endtask

    // one-cycle event pulse, returns mid-cycle after the design sampled it
    task automatic fire(input logic [4:0] m);
        @(posedge hclk);
        ev <= m;
        @(posedge hclk);
        ev <= '0;
        @(negedge hclk);
    endtask

    // waits for a low-to-high step of the switch output
    task automatic rise();
        logic p;
        logic q;
        q = 1'b1;
        do begin
            @(negedge hclk);
            p = q;
            q = pulse_out;
        end while (!(p === 1'b0 && q === 1'b1));
    endtask

    task automatic hold(input int n);
        h = 0;
        repeat (n) begin
            @(negedge hclk);
            if (pulse_out === 1'b1) h = h + 1;
        end
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors = errors + 1;
            results();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rdchk(ROWS[i].idx, ROWS[i].rst);
            wr(ROWS[i].idx, ROWS[i].wd);
            rdchk(ROWS[i].idx, ROWS[i].exp);
        end
        @(negedge hclk);
        check(cfg, 8'hDE);
        check(frame_based_wake_en, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(IDX_SWK, {1'b1, i[1:0], 5'h10});
            @(negedge hclk);
            check(cfg.trim_unlocked, i == 3);
            check(cfg.osc_trim_mode, 1'b1);
        end
        fire(5'h01);
        check(irq_out_n, 1'b0);
        wr(IDX_SWK, 8'h00);
        fire(5'h01);
        check(irq_out_n, 1'b1);
        for (int i = 1; i < 3; i++) begin
            wr(IDX_SWK, 8'h01);
            fire(5'(1 << i));
            rdchk(IDX_SWK, 8'h00);
            check(frame_based_wake_en, 1'b0);
        end
        normal_mode <= 1'b0;
        wr(IDX_SCR_LO, 8'h11);
        rdchk(IDX_SCR_LO, 8'hA5);
        normal_mode <= 1'b1;
        wr(IDX_SWK, 8'hF1);
        fire(5'h10);
        for (int i = 0; i < 6; i++) begin
            rdchk(ROWS[i].idx, (i == 2 || i == 3) ? ROWS[i].exp : ROWS[i].rst);
        end
        wr(IDX_THERM, 8'h06);
        fire(5'h08);
        rdchk(IDX_SCR_HI, 8'h5A);
        rdchk(IDX_THERM, 8'h06);
        wr(IDX_LOCK, 8'h01);
        @(negedge hclk);
        check(cfg.cfg_locked, 1'b0);
        @(posedge hclk);
        chip_select_n <= 1'b0;
        repeat (3) @(posedge hclk);
        chip_select_n <= 1'b1;
        repeat (8) @(negedge hclk);
        check(cfg.cfg_locked, 1'b1);
        wr(IDX_THERM, 8'h01);
        rdchk(IDX_THERM, 8'h06);
        fire(5'h10);
        rdchk(IDX_THERM, 8'h06);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(IDX_SCR_LO, 8'h00);
        rdchk(IDX_SCR_HI, 8'h00);
        check(cfg.cfg_locked, 1'b0);
        wr(IDX_DUTY, 8'h80);
        pulse_pin_enable <= 1'b1;
        for (int i = 1; i < 5; i++) begin
            rise();
            t0 = cyc;
            wr(IDX_RATE, 8'(i % 4));
            rise();
            check(cyc - t0, PER[i - 1]);
            t0 = cyc;
            rise();
            check(cyc - t0, PER[i % 4]);
        end
        rise();
        wr(IDX_DUTY, 8'hFF);
        hold(150);
        check(h < 150, 1'b1);
        hold(300);
        hold(200);
        check(h, 200);
        wr(IDX_DUTY, 8'h00);
        hold(300);
        hold(200);
        check(h, 0);
        results();
    end
endmodule
